// ===== design/spirq_map.svh
// register map, field positions, reset values and timing counts of the serial port irq block
`ifndef SPIRQ_MAP_SVH
`define SPIRQ_MAP_SVH

`define SPIRQ_ADDR_PRESCALE    32'h40040010
`define SPIRQ_ADDR_ENABLE      32'h40040014
`define SPIRQ_ADDR_RAW         32'h40040018
`define SPIRQ_ADDR_ENABLED     32'h4004001c
`define SPIRQ_ADDR_CLEAR       32'h40040020
`define SPIRQ_ADDR_RATE        32'h40040024
`define SPIRQ_ADDR_EVENT       32'h40040028
`define SPIRQ_ADDR_EVENT_MASK  32'h4004002c

`define SPIRQ_BIT_OVERRUN      0
`define SPIRQ_BIT_TIMEOUT      1
`define SPIRQ_BIT_RX_HALF      2
`define SPIRQ_BIT_TX_HALF      3
`define SPIRQ_NUM_FLAGS        4

`define SPIRQ_RAW_RESET        4'h8
`define SPIRQ_ENABLE_RESET     4'h0
`define SPIRQ_BYTE_RESET       8'h00
`define SPIRQ_PRESCALE_KEEP    8'hfe

`define SPIRQ_TIMEOUT_BITS     32
`define SPIRQ_CNT_W            21

`endif

// ===== design/spirq_pkg.sv
// types shared by the serial port irq block
package spirq_pkg;

  // status coming from the fifo and shifter logic on the same clock
  typedef struct packed {
    logic rxFrameDone;
    logic rxFifoFull;
    logic rxFifoEmpty;
    logic rxFifoRead;
    logic rxHalfFull;
    logic txHalfEmpty;
  } spirq_fifo_t;

  // one bit per condition, bit 0 is overrun
  typedef struct packed {
    logic txHalfEmpty;
    logic rxHalfFull;
    logic rxTimeout;
    logic overrun;
  } spirq_flags_t;

  typedef enum logic {
    SPIRQ_BUS_WAIT,
    SPIRQ_BUS_ANSWER
  } spirq_bus_t;

endpackage

// ===== design/spirq_timeout.sv
// receive time-out counter: unread data waiting for 32 serial bit times
`timescale 1ns/1ns
`default_nettype none
`include "spirq_map.svh"

module spirq_timeout (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       rxFifoEmpty,
  input  wire logic       rxFifoRead,
  input  wire logic [7:0] prescaleDivisor,
  input  wire logic [7:0] rateFactor,
  output var  logic       timeoutHit
);

  function automatic logic [`SPIRQ_CNT_W-1:0] periodCycles(
    input logic [7:0] div,
    input logic [7:0] rate
  );
    logic [`SPIRQ_CNT_W-1:0] bitCycles;
    bitCycles = `SPIRQ_CNT_W'(div) * (`SPIRQ_CNT_W'(rate) + `SPIRQ_CNT_W'(1));
    return bitCycles * `SPIRQ_CNT_W'(`SPIRQ_TIMEOUT_BITS);
  endfunction

  logic [`SPIRQ_CNT_W-1:0] waitCount;
  logic [`SPIRQ_CNT_W-1:0] limit;
  logic                    restart;
  logic                    reached;

  assign limit   = periodCycles(prescaleDivisor, rateFactor);
  // a zero divisor means no bit clock, so the counter stays parked
  assign restart = rxFifoEmpty || rxFifoRead || (limit == '0);
  assign reached = !restart && (waitCount == limit - `SPIRQ_CNT_W'(1));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      waitCount  <= '0;
      timeoutHit <= 1'b0;
    end else begin
      timeoutHit <= reached;
      if (restart) begin
        waitCount <= '0;
      end else if (waitCount != limit) begin
        // holds at the limit so one wait gives one pulse
        waitCount <= waitCount + `SPIRQ_CNT_W'(1);
      end
    end
  end

endmodule
`default_nettype wire

// ===== design/spirq_ctrl.sv
// serial port interrupt status, enable and clear logic behind an avalon-mm slave
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "spirq_map.svh"

module spirq_ctrl
  import spirq_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [31:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  input  wire spirq_fifo_t fifoStatus,
  output var  logic        overwriteLast,
  output var  logic [7:0]  prescaleDivisor,
  output var  logic [7:0]  serialClockRateFactor,
  output var  logic        irq
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  spirq_bus_t   busState;
  spirq_bus_t   next_busState;
  spirq_flags_t rawFlags;
  spirq_flags_t next_rawFlags;
  spirq_flags_t enableFlags;
  spirq_flags_t next_enableFlags;
  spirq_flags_t eventLog;
  spirq_flags_t next_eventLog;
  spirq_flags_t eventMask;
  spirq_flags_t next_eventMask;
  spirq_flags_t rawLast;
  spirq_flags_t enabledFlags;
  spirq_flags_t risingFlags;
  spirq_flags_t reportedLog;
  logic [7:0]   next_prescaleDivisor;
  logic [7:0]   next_serialClockRateFactor;
  logic [31:0]  next_readdata;
  logic         timeoutHit;
  logic         overrunEvent;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic hitPrescale;
  logic hitEnable;
  logic hitRaw;
  logic hitEnabled;
  logic hitClear;
  logic hitRate;
  logic hitEvent;
  logic hitEventMask;
  logic lowLane;
  logic takeNow;
  logic writeNow;
  logic readNow;

  // full 32-bit compare, so aliases of a register read as unmapped
  function automatic logic addrIs(
    input logic [31:0] addr,
    input logic [31:0] target
  );
    return (addr == target);
  endfunction

  // every flag register keeps its fields in the lowest bits of the word
  function automatic spirq_flags_t flagsOf(
    input logic [31:0] word
  );
    return spirq_flags_t'(word[`SPIRQ_NUM_FLAGS-1:0]);
  endfunction

  assign hitPrescale  = addrIs(avs_address, `SPIRQ_ADDR_PRESCALE);
  assign hitEnable    = addrIs(avs_address, `SPIRQ_ADDR_ENABLE);
  assign hitRaw       = addrIs(avs_address, `SPIRQ_ADDR_RAW);
  assign hitEnabled   = addrIs(avs_address, `SPIRQ_ADDR_ENABLED);
  assign hitClear     = addrIs(avs_address, `SPIRQ_ADDR_CLEAR);
  assign hitRate      = addrIs(avs_address, `SPIRQ_ADDR_RATE);
  assign hitEvent     = addrIs(avs_address, `SPIRQ_ADDR_EVENT);
  assign hitEventMask = addrIs(avs_address, `SPIRQ_ADDR_EVENT_MASK);

  // every field lives in byte lane 0, the other lanes only carry reserved bits
  assign lowLane  = avs_byteenable[0];
  // the master samples waitrequest low at this edge, so effects land here only
  assign takeNow  = (busState == SPIRQ_BUS_ANSWER);
  assign writeNow = takeNow && avs_write && lowLane;
  assign readNow  = takeNow && avs_read;

  logic writeEnable;
  logic writeClear;
  logic writePrescale;
  logic writeRate;
  logic writeEventMask;
  logic readEvent;

  assign writeEnable    = writeNow && hitEnable;
  assign writeClear     = writeNow && hitClear;
  assign writePrescale  = writeNow && hitPrescale;
  assign writeRate      = writeNow && hitRate;
  assign writeEventMask = writeNow && hitEventMask;
  assign readEvent      = readNow && hitEvent;

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle, then one answer cycle

  always_comb begin
    next_busState = busState;
    case (busState)
      SPIRQ_BUS_WAIT: begin
        if (avs_read || avs_write) begin
          next_busState = SPIRQ_BUS_ANSWER;
        end
      end
      SPIRQ_BUS_ANSWER: begin
        next_busState = SPIRQ_BUS_WAIT;
      end
      default: begin
        next_busState = SPIRQ_BUS_WAIT;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive time-out

  spirq_timeout u_timeout (
    .clk             (clk),
    .rst_n           (rst_n),
    .rxFifoEmpty     (fifoStatus.rxFifoEmpty),
    .rxFifoRead      (fifoStatus.rxFifoRead),
    .prescaleDivisor (prescaleDivisor),
    .rateFactor      (serialClockRateFactor),
    .timeoutHit      (timeoutHit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // condition flags

  assign overrunEvent = fifoStatus.rxFrameDone && fifoStatus.rxFifoFull;

  always_comb begin
    next_rawFlags = rawFlags;
    if (writeClear && avs_writedata[`SPIRQ_BIT_OVERRUN]) begin
      next_rawFlags.overrun = 1'b0;
    end
    if (writeClear && avs_writedata[`SPIRQ_BIT_TIMEOUT]) begin
      next_rawFlags.rxTimeout = 1'b0;
    end
    if (overrunEvent) begin
      next_rawFlags.overrun = 1'b1;
    end
    if (timeoutHit) begin
      next_rawFlags.rxTimeout = 1'b1;
    end
    next_rawFlags.rxHalfFull  = fifoStatus.rxHalfFull;
    next_rawFlags.txHalfEmpty = fifoStatus.txHalfEmpty;
  end

  assign enabledFlags = rawFlags & enableFlags;

  ////////////////////////////////////////////////////////////////////////////
  // configuration

  always_comb begin
    next_enableFlags           = enableFlags;
    next_prescaleDivisor       = prescaleDivisor;
    next_serialClockRateFactor = serialClockRateFactor;
    next_eventMask             = eventMask;
    if (writeEnable) begin
      next_enableFlags = flagsOf(avs_writedata);
    end
    if (writePrescale) begin
      next_prescaleDivisor = avs_writedata[7:0] & `SPIRQ_PRESCALE_KEEP;
    end
    if (writeRate) begin
      next_serialClockRateFactor = avs_writedata[7:0];
    end
    if (writeEventMask) begin
      next_eventMask = flagsOf(avs_writedata);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event log: rising conditions, cleared by reading it

  assign risingFlags = rawFlags & ~rawLast;
  // only what the answer showed is cleared, so a later rise is kept
  assign reportedLog = readEvent ?
                       flagsOf(avs_readdata) :
                       spirq_flags_t'(`SPIRQ_ENABLE_RESET);
  assign next_eventLog = (eventLog & ~reportedLog) | risingFlags;

  ////////////////////////////////////////////////////////////////////////////
  // read data, sampled one cycle before the answer

  always_comb begin
    next_readdata = avs_readdata;
    if (busState == SPIRQ_BUS_WAIT && avs_read) begin
      next_readdata = '0;
      if (hitPrescale) begin
        next_readdata[7:0] = prescaleDivisor;
      end else if (hitEnable) begin
        next_readdata[`SPIRQ_NUM_FLAGS-1:0] = enableFlags;
      end else if (hitRaw) begin
        next_readdata[`SPIRQ_NUM_FLAGS-1:0] = rawFlags;
      end else if (hitEnabled) begin
        next_readdata[`SPIRQ_NUM_FLAGS-1:0] = enabledFlags;
      end else if (hitRate) begin
        next_readdata[7:0] = serialClockRateFactor;
      end else if (hitEvent) begin
        next_readdata[`SPIRQ_NUM_FLAGS-1:0] = eventLog;
      end else if (hitEventMask) begin
        next_readdata[`SPIRQ_NUM_FLAGS-1:0] = eventMask;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busState        <= SPIRQ_BUS_WAIT;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
    end else begin
      busState        <= next_busState;
      avs_waitrequest <= (next_busState != SPIRQ_BUS_ANSWER);
      avs_readdata    <= next_readdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rawFlags <= spirq_flags_t'(`SPIRQ_RAW_RESET);
      rawLast  <= spirq_flags_t'(`SPIRQ_RAW_RESET);
    end else begin
      rawFlags <= next_rawFlags;
      rawLast  <= rawFlags;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enableFlags           <= spirq_flags_t'(`SPIRQ_ENABLE_RESET);
      eventMask             <= spirq_flags_t'(`SPIRQ_ENABLE_RESET);
      eventLog              <= spirq_flags_t'(`SPIRQ_ENABLE_RESET);
      prescaleDivisor       <= `SPIRQ_BYTE_RESET;
      serialClockRateFactor <= `SPIRQ_BYTE_RESET;
    end else begin
      enableFlags           <= next_enableFlags;
      eventMask             <= next_eventMask;
      eventLog              <= next_eventLog;
      prescaleDivisor       <= next_prescaleDivisor;
      serialClockRateFactor <= next_serialClockRateFactor;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt request

  logic levelCause;
  logic logCause;
  logic next_irq;

  // built from next values so irq rises with the flag, not an edge later
  // or of enabled bits
  assign levelCause = |(next_rawFlags & next_enableFlags);
  assign logCause   = |(next_eventLog & next_eventMask);
  assign next_irq   = levelCause || logCause;

  ////////////////////////////////////////////////////////////////////////////
  // outputs toward the fifo and the interrupt controller

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      overwriteLast <= 1'b0;
      irq           <= 1'b0;
    end else begin
      overwriteLast <= overrunEvent;
      irq           <= next_irq;
    end
  end

endmodule
`default_nettype wire

// ===== sim/spirq_ctrl_asserts.sv
// port checks for the serial port irq block
`timescale 1ns/1ns
`default_nettype none
`include "spirq_map.svh"

module spirq_ctrl_asserts
  import spirq_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [31:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire spirq_fifo_t fifoStatus,
  input wire logic        overwriteLast,
  input wire logic [7:0]  prescaleDivisor,
  input wire logic        irq
);
  wire logic       ovrEvent = fifoStatus.rxFrameDone & fifoStatus.rxFifoFull;
  wire logic       taken    = (avs_read | avs_write) & avs_waitrequest;
  wire logic       rdDone   = avs_read & ~avs_waitrequest;
  wire logic       rawRd    = avs_read & avs_waitrequest & (avs_address == `SPIRQ_ADDR_RAW);
  wire logic [1:0] lvl      = {fifoStatus.txHalfEmpty, fifoStatus.rxHalfFull};
  logic      [1:0] lvlQ;
  wire logic       cause    = (avs_write & ~avs_waitrequest) | (lvl != lvlQ) | ovrEvent |
                              ~fifoStatus.rxFifoEmpty;

  // level one cycle back, so a move of a fifo level counts as a cause
  always_ff @(posedge clk) begin
    lvlQ <= lvl;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////////
  property p_ovrSet;
    ovrEvent |=> overwriteLast;
  endproperty
  a_ovrSet: assert property (p_ovrSet)
    else $error("overrun event not flagged");
  property p_ovrNot;
    !ovrEvent |=> !overwriteLast;
  endproperty
  a_ovrNot: assert property (p_ovrNot)
    else $error("overwrite pulse without overrun");
  property p_ans;
    taken |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_ans: assert property (p_ans)
    else $error("bus answer not one cycle");
  property p_rsvdRd;
    rdDone |-> avs_readdata[31:8] == 24'h0;
  endproperty
  a_rsvdRd: assert property (p_rsvdRd)
    else $error("reserved read bits set");
  property p_clrRd;
    rdDone && avs_address == `SPIRQ_ADDR_CLEAR |-> avs_readdata == 32'h0;
  endproperty
  a_clrRd: assert property (p_clrRd)
    else $error("clear register read nonzero");
  property p_presEven;
    prescaleDivisor[0] == 1'b0;
  endproperty
  a_presEven: assert property (p_presEven)
    else $error("prescale bit 0 set");
  property p_rawLvl;
    rawRd && $stable(lvl) && $past(rst_n) |=> avs_readdata[3:2] == $past(lvl);
  endproperty
  a_rawLvl: assert property (p_rawLvl)
    else $error("raw level bits wrong");
  property p_irqLvl;
    $rose(irq) |-> $past(cause) || $past(cause, 2) || $past(cause, 3);
  endproperty
  a_irqLvl: assert property (p_irqLvl)
    else $error("irq rose without cause");
  c_ovr: cover property (overwriteLast);
  c_irq: cover property ($rose(irq));
  c_rd: cover property (rawRd);
  c_log: cover property (rdDone && avs_address == `SPIRQ_ADDR_EVENT);
endmodule

bind spirq_ctrl spirq_ctrl_asserts u_chk (
  .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .fifoStatus(fifoStatus), .overwriteLast(overwriteLast),
  .prescaleDivisor(prescaleDivisor), .irq(irq)
);
`default_nettype wire

// ===== sim/spirq_ctrl_tb.sv
// self-checking bench for the serial port irq block
`timescale 1ns/1ns
`default_nettype none
`include "spirq_map.svh"

module spirq_ctrl_tb
  import spirq_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [31:0] avs_address = 32'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  spirq_fifo_t fs = 6'h09;
  logic        overwriteLast;
  logic [7:0]  prescaleDivisor;
  logic [7:0]  rateFactor;
  logic        irq;
  int          miscompares = 0;
  int          checked = 0;
  logic [31:0] q;

  always #5 clk = ~clk;

  spirq_ctrl dut (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .fifoStatus(fs),
    .overwriteLast(overwriteLast), .prescaleDivisor(prescaleDivisor),
    .serialClockRateFactor(rateFactor), .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // request held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      miscompares++;
      final_report();
    end
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask

  // irq is registered, so let the update land first
  task automatic irqc(input logic e);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask

  task automatic ovr();
    @(posedge clk);
    fs.rxFrameDone <= 1'b1;
    fs.rxFifoFull <= 1'b1;
    @(posedge clk);
    fs.rxFrameDone <= 1'b0;
    fs.rxFifoFull <= 1'b0;
    @(posedge clk);
    chk({31'h0, overwriteLast}, 32'h1);
    @(posedge clk);
    chk({31'h0, overwriteLast}, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(`SPIRQ_ADDR_RAW, 32'h8);
    rd(`SPIRQ_ADDR_ENABLE, 32'h0);
    rd(`SPIRQ_ADDR_ENABLED, 32'h0);
    irqc(1'b0);
    wr(`SPIRQ_ADDR_ENABLE, 32'hf);
    rd(`SPIRQ_ADDR_ENABLED, 32'h8);
    irqc(1'b1);
    wr(`SPIRQ_ADDR_ENABLE, 32'h0);
    irqc(1'b0);
    ovr();
    rd(`SPIRQ_ADDR_RAW, 32'h9);
    avs_byteenable <= 4'h0;
    wr(`SPIRQ_ADDR_CLEAR, 32'h1);
    avs_byteenable <= 4'hf;
    rd(`SPIRQ_ADDR_RAW, 32'h9);
    wr(`SPIRQ_ADDR_CLEAR, 32'h0);
    rd(`SPIRQ_ADDR_RAW, 32'h9);
    wr(`SPIRQ_ADDR_ENABLE, 32'h1);
    irqc(1'b1);
    rd(`SPIRQ_ADDR_ENABLED, 32'h1);
    wr(`SPIRQ_ADDR_CLEAR, 32'h1);
    rd(`SPIRQ_ADDR_RAW, 32'h8);
    irqc(1'b0);
    rd(`SPIRQ_ADDR_CLEAR, 32'h0);
    rd(32'h40040030, 32'h0);
    // divisor 2, rate 0: time-out after 64 cycles
    wr(`SPIRQ_ADDR_PRESCALE, 32'h3);
    rd(`SPIRQ_ADDR_PRESCALE, 32'h2);
    chk({24'h0, prescaleDivisor}, 32'h2);
    fs.rxFifoEmpty <= 1'b0;
    repeat (30) @(posedge clk);
    rd(`SPIRQ_ADDR_RAW, 32'h8);
    repeat (40) @(posedge clk);
    rd(`SPIRQ_ADDR_RAW, 32'ha);
    ovr();
    rd(`SPIRQ_ADDR_RAW, 32'hb);
    fs.rxFifoEmpty <= 1'b1;
    wr(`SPIRQ_ADDR_CLEAR, 32'h3);
    rd(`SPIRQ_ADDR_RAW, 32'h8);
    fs <= 6'h0a;
    repeat (2) @(posedge clk);
    rd(`SPIRQ_ADDR_RAW, 32'h4);
    wr(`SPIRQ_ADDR_CLEAR, 32'h3);
    rd(`SPIRQ_ADDR_RAW, 32'h4);
    wr(`SPIRQ_ADDR_ENABLE, 32'h4);
    irqc(1'b1);
    rd(`SPIRQ_ADDR_ENABLED, 32'h4);
    fs <= 6'h09;
    irqc(1'b0);
    wr(`SPIRQ_ADDR_RATE, 32'h1);
    rd(`SPIRQ_ADDR_RATE, 32'h1);
    chk({24'h0, rateFactor}, 32'h1);
    // divisor 2, rate 1: time-out after 128 cycles
    fs.rxFifoEmpty <= 1'b0;
    repeat (100) @(posedge clk);
    rd(`SPIRQ_ADDR_RAW, 32'h8);
    repeat (40) @(posedge clk);
    rd(`SPIRQ_ADDR_RAW, 32'ha);
    fs.rxFifoEmpty <= 1'b1;
    wr(`SPIRQ_ADDR_CLEAR, 32'h2);
    rd(`SPIRQ_ADDR_RAW, 32'h8);
    // every raw bit has risen once by now
    wr(`SPIRQ_ADDR_EVENT_MASK, 32'h8);
    irqc(1'b1);
    rd(`SPIRQ_ADDR_EVENT, 32'hf);
    irqc(1'b0);
    rd(`SPIRQ_ADDR_EVENT, 32'h0);
    // second reset in mid-run
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(`SPIRQ_ADDR_ENABLE, 32'h0);
    rd(`SPIRQ_ADDR_PRESCALE, 32'h0);
    rd(`SPIRQ_ADDR_EVENT_MASK, 32'h0);
    rd(`SPIRQ_ADDR_RAW, 32'h8);
    chk({31'h0, irq}, 32'h0);
    final_report();
  end
endmodule
`default_nettype wire
